// [inc/amm_pkg.sv]
// Types shared by the min/max tracker.
// Assumes amm_regs.svh is on the include path.
`include "amm_regs.svh"

package amm_pkg;

    typedef logic [9:0] amm_val_t;

    typedef enum logic [1:0] {
        AMM_MODE_MIN  = 2'h0,
        AMM_MODE_MAX  = 2'h1,
        AMM_MODE_SEL  = 2'h2,
        AMM_MODE_PASS = 2'h3
    } amm_mode_t;

    typedef struct packed {
        logic [5:0] scan_cnt;
        logic       scan_tick;
        amm_mode_t  mode;
        logic       zero_on_disable;
        logic       mode_from_block;
        amm_val_t   lower;
        amm_val_t   upper;
        amm_val_t   result;
        amm_val_t   min_val;
        amm_val_t   max_val;
        logic       have_sample;
        logic       select_last;
        logic [31:0] prdata;
    } amm_state_t;

endpackage : amm_pkg

// [inc/amm_regs.svh]
// Offsets, field positions, reset values and timing counts of the min/max tracker.
// Assumes inclusion from the package and the testbench only.
`ifndef AMM_REGS_SVH
`define AMM_REGS_SVH

// Register byte addresses
`define AMM_CTRL_OFS        12'h000
`define AMM_LOWER_OFS       12'h004
`define AMM_UPPER_OFS       12'h008
`define AMM_RESULT_OFS      12'h00C
`define AMM_EXTREME_OFS     12'h010

// Control fields
`define AMM_CTRL_MODE_LSB   0
`define AMM_CTRL_MODE_MSB   1
`define AMM_CTRL_ZERO_BIT   2
`define AMM_CTRL_REF_BIT    3

// Extreme register fields
`define AMM_EXT_MIN_LSB     0
`define AMM_EXT_MAX_LSB     16

// Reset values
`define AMM_CTRL_RST        4'h0
`define AMM_LOWER_RST       10'h000
`define AMM_UPPER_RST       10'h3E8

// Analogue full scale
`define AMM_FULL_SCALE      10'h3E8

// Program cycle timing
`define AMM_CLK_NS          20
`define AMM_SCAN_NS         1000
`define AMM_SCAN_CYC        ((`AMM_SCAN_NS) / (`AMM_CLK_NS))

`endif

// [rtl/amm_tracker.sv]
// Analogue min/max tracker with limit clamp, APB register slave.
// Assumes analog_source, block_enable and extreme_select come from logic on clk.
//
// Notes on behaviour
// - Reset-on-disable chosen and enable low: result goes to zero.
// - Reset-on-disable not chosen and enable low: result holds.
// - Enable high: result follows mode and select, either option.
// - Mode zero: result shows tracked minimum.
// - Mode one: result shows tracked maximum.
// - Mode two: select low gives minimum, select high gives maximum.
// - Mode three or block-referenced mode: input passes straight through.
// - Result below lower limit is replaced by lower limit, or by upper limit if upper is below lower.
// - Result above upper limit is replaced by upper limit.
// - Mode two: select rising edge picks maximum, falling edge minimum.
// - Mode is two bits, values zero to three; scale runs 0 to 1000.
`timescale 1ns/1ps

module amm_tracker
    import amm_pkg::*;
(
    input  wire logic        clk,
    input  wire logic        arst_n,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [11:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic [31:0]      prdata,
    output logic             pready,
    output logic             pslverr,
    input  wire logic [9:0]  analog_source,
    input  wire logic        block_enable,
    input  wire logic        extreme_select,
    output logic [9:0]       analog_result
);

    ////////////////////////////////////////////////////////////////////////////
    // Reset release

    logic [1:0] rst_sync;
    logic       rst_n;

    always_ff @(posedge clk or negedge arst_n) begin
        if (!arst_n) begin
            rst_sync <= 2'h0;
        end else begin
            rst_sync <= {rst_sync[0], 1'b1};
        end
    end

    assign rst_n = rst_sync[1];

    ////////////////////////////////////////////////////////////////////////////
    // Helpers

    // Lower limit first, so an upper limit below the lower one wins
    function automatic amm_val_t amm_clamp(input amm_val_t v, input amm_val_t lo, input amm_val_t hi);
        amm_val_t t;
        t = (v < lo) ? lo : v;
        t = (t > hi) ? hi : t;
        return t;
    endfunction : amm_clamp

    function automatic amm_val_t amm_scale(input logic [31:0] w);
        return (w[9:0] > `AMM_FULL_SCALE || w[31:10] != 22'h0) ? `AMM_FULL_SCALE : w[9:0];
    endfunction : amm_scale

    ////////////////////////////////////////////////////////////////////////////
    // State

    amm_state_t st_reg;
    amm_state_t st_next;
    amm_val_t   src;
    amm_val_t   new_min;
    amm_val_t   new_max;
    amm_val_t   pick;
    logic       setup;
    logic       wr_en;
    logic       hit;

    assign src     = amm_scale({22'h0, analog_source});
    assign setup   = psel && !penable;
    assign wr_en   = psel && penable && pwrite;
    assign hit     = (paddr == `AMM_CTRL_OFS) || (paddr == `AMM_LOWER_OFS) || (paddr == `AMM_UPPER_OFS) ||
                     (paddr == `AMM_RESULT_OFS) || (paddr == `AMM_EXTREME_OFS);
    assign pready  = psel && penable;
    assign pslverr = psel && penable && !hit;

    always_comb begin
        st_next = st_reg;
        // Program cycle divider
        st_next.scan_tick = 1'b0;
        if (st_reg.scan_cnt == 6'(`AMM_SCAN_CYC - 1)) begin
            st_next.scan_cnt  = 6'h0;
            st_next.scan_tick = 1'b1;
        end else begin
            st_next.scan_cnt = st_reg.scan_cnt + 6'h1;
        end

        // First sample seeds both extremes
        new_min = (!st_reg.have_sample || src < st_reg.min_val) ? src : st_reg.min_val;
        new_max = (!st_reg.have_sample || src > st_reg.max_val) ? src : st_reg.max_val;

        // Level of select equals the state its last edge chose
        case (st_reg.mode)
            AMM_MODE_MIN:  pick = new_min;
            AMM_MODE_MAX:  pick = new_max;
            AMM_MODE_SEL:  pick = extreme_select ? new_max : new_min;
            default:       pick = src;
        endcase
        if (st_reg.mode_from_block) begin
            pick = src;
        end

        if (st_reg.scan_tick) begin
            st_next.select_last = extreme_select;
            if (block_enable) begin
                st_next.min_val     = new_min;
                st_next.max_val     = new_max;
                st_next.have_sample = 1'b1;
                st_next.result      = amm_clamp(pick, st_reg.lower, st_reg.upper);
            end else if (st_reg.zero_on_disable) begin
                st_next.result      = 10'h000;
                st_next.min_val     = 10'h000;
                st_next.max_val     = 10'h000;
                st_next.have_sample = 1'b0;
            end
            // Otherwise result and extremes hold
        end

        // APB writes take effect in the access phase
        if (wr_en) begin
            if (paddr == `AMM_CTRL_OFS) begin
                st_next.mode            = amm_mode_t'(pwdata[`AMM_CTRL_MODE_MSB:`AMM_CTRL_MODE_LSB]);
                st_next.zero_on_disable = pwdata[`AMM_CTRL_ZERO_BIT];
                st_next.mode_from_block = pwdata[`AMM_CTRL_REF_BIT];
            end else if (paddr == `AMM_LOWER_OFS) begin
                st_next.lower = amm_scale(pwdata);
            end else if (paddr == `AMM_UPPER_OFS) begin
                st_next.upper = amm_scale(pwdata);
            end
        end

        // Read data is latched in the setup phase and held through access
        if (setup) begin
            if (paddr == `AMM_CTRL_OFS) begin
                st_next.prdata = {28'h0, st_reg.mode_from_block, st_reg.zero_on_disable, st_reg.mode};
            end else if (paddr == `AMM_LOWER_OFS) begin
                st_next.prdata = {22'h0, st_reg.lower};
            end else if (paddr == `AMM_UPPER_OFS) begin
                st_next.prdata = {22'h0, st_reg.upper};
            end else if (paddr == `AMM_RESULT_OFS) begin
                st_next.prdata = {22'h0, st_reg.result};
            end else if (paddr == `AMM_EXTREME_OFS) begin
                st_next.prdata = {6'h0, st_reg.max_val, 6'h0, st_reg.min_val};
            end else begin
                st_next.prdata = 32'h0;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            st_reg                 <= '0;
            st_reg.mode            <= amm_mode_t'(2'(`AMM_CTRL_RST));
            st_reg.lower           <= `AMM_LOWER_RST;
            st_reg.upper           <= `AMM_UPPER_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    assign prdata        = st_reg.prdata;
    assign analog_result = st_reg.result;

    ////////////////////////////////////////////////////////////////////////////
    // Checks

    a_disable_zero: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && !block_enable && st_reg.zero_on_disable |=> analog_result == 10'h000)
        else $error("result not zeroed on disable");

    a_disable_hold: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && !block_enable && !st_reg.zero_on_disable |=> $stable(analog_result))
        else $error("result moved while disabled");

    a_mode_min: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && st_reg.mode == AMM_MODE_MIN && !st_reg.mode_from_block
        |=> analog_result == amm_clamp(st_reg.min_val, st_reg.lower, st_reg.upper))
        else $error("mode zero result is not the minimum");

    a_mode_max: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && st_reg.mode == AMM_MODE_MAX && !st_reg.mode_from_block
        |=> analog_result == amm_clamp(st_reg.max_val, st_reg.lower, st_reg.upper))
        else $error("mode one result is not the maximum");

    a_mode_select: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && st_reg.mode == AMM_MODE_SEL && !st_reg.mode_from_block
        |=> analog_result == amm_clamp(st_reg.select_last ? st_reg.max_val : st_reg.min_val,
                                       st_reg.lower, st_reg.upper))
        else $error("mode two result does not follow select");

    a_pass_through: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && (st_reg.mode == AMM_MODE_PASS || st_reg.mode_from_block)
        |=> analog_result == amm_clamp($past(src), st_reg.lower, st_reg.upper))
        else $error("pass mode result is not the input");

    a_limit_low: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && st_reg.lower <= st_reg.upper
        |=> analog_result >= st_reg.lower)
        else $error("result below lower limit");

    a_limit_high: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en |=> analog_result <= st_reg.upper)
        else $error("result above upper limit");

    a_scale_range: assert property (@(posedge clk) disable iff (!rst_n)
        analog_result <= `AMM_FULL_SCALE && st_reg.upper <= `AMM_FULL_SCALE)
        else $error("value beyond full scale");

    a_extreme_order: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.have_sample |-> st_reg.min_val <= st_reg.max_val)
        else $error("minimum above maximum");

    a_tick_spacing: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick |=> !st_reg.scan_tick [*8])
        else $error("program cycles too close");

    a_rise_to_max: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && st_reg.mode == AMM_MODE_SEL && !st_reg.mode_from_block
        && extreme_select && !st_reg.select_last
        |=> analog_result == amm_clamp(st_reg.max_val, st_reg.lower, st_reg.upper))
        else $error("rising select did not pick maximum");

    a_fall_to_min: assert property (@(posedge clk) disable iff (!rst_n)
        st_reg.scan_tick && block_enable && !wr_en && st_reg.mode == AMM_MODE_SEL && !st_reg.mode_from_block
        && !extreme_select && st_reg.select_last
        |=> analog_result == amm_clamp(st_reg.min_val, st_reg.lower, st_reg.upper))
        else $error("falling select did not pick minimum");

endmodule : amm_tracker

// [tb/amm_source_model.sv]
// Stand-in for the program blocks that feed the min/max tracker.
// Assumes the bench sets the wanted values just after a rising edge of clk.
`timescale 1ns/1ps

module amm_source_model (
    input  wire logic       clk,
    input  wire logic [9:0] want_value,
    input  wire logic       want_enable,
    input  wire logic       want_select,
    output logic [9:0]      analog_source,
    output logic            block_enable,
    output logic            extreme_select
);
    // Values leave on the 0 to 1000 scale, one clock after the request
    always_ff @(posedge clk) begin
        analog_source  <= (want_value > 10'h3E8) ? 10'h3E8 : want_value;
        block_enable   <= want_enable;
        extreme_select <= want_select;
    end
endmodule : amm_source_model

// [tb/testbench.sv]
// Self-checking bench of the min/max tracker, registers over APB.
// Assumes program-cycle ticks every 50 clocks, so 120 clocks span two ticks.
`timescale 1ns/1ps
`include "amm_regs.svh"

module testbench;
    import amm_pkg::*;
    logic        clk = 1'b0;
    logic        arst_n = 1'b0;
    logic        psel = 1'b0;
    logic        penable = 1'b0;
    logic        pwrite = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic        pready;
    logic        pslverr;
    logic [9:0]  want_value = 10'h1F4;
    logic        want_enable = 1'b1;
    logic        want_select = 1'b0;
    logic [9:0]  analog_source;
    logic        block_enable;
    logic        extreme_select;
    logic [9:0]  analog_result;
    logic [31:0] rd;
    logic        err;
    int          failures = 0;
    int          compares = 0;

    always #10 clk = ~clk;

    amm_tracker i_dut (.clk(clk), .arst_n(arst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .analog_source(analog_source), .block_enable(block_enable), .extreme_select(extreme_select),
        .analog_result(analog_result));
    amm_source_model i_src (.clk(clk), .want_value(want_value), .want_enable(want_enable),
        .want_select(want_select), .analog_source(analog_source), .block_enable(block_enable),
        .extreme_select(extreme_select));

    ////////////////////////////////////////////////////////////////////////
    task automatic test_done;
        if (failures == 0 && compares > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : test_done

    task automatic cmp(input string what, input logic [31:0] exp, input logic [31:0] got);
        compares++;
        if (got !== exp) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, exp, got);
        end
    endtask : cmp

    // Waits for pready as long as it takes; only the watchdog ends a hang
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        @(posedge clk);
        psel    <= 1'b1;
        penable <= 1'b0;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask : apb

    // Sets the source, then lets two program cycles pass
    task automatic drive(input logic [9:0] v, input logic en, input logic sel);
        want_value  <= v;
        want_enable <= en;
        want_select <= sel;
        repeat (120) @(posedge clk);
    endtask : drive

    // Output is looked at half a cycle after the edge that may launch it
    task automatic chk_res(input logic [9:0] e);
        @(negedge clk);
        cmp("analog_result", {22'h0, e}, {22'h0, analog_result});
        apb(1'b0, `AMM_RESULT_OFS, 32'h0);
        cmp("result_reg", {22'h0, e}, rd);
    endtask : chk_res

    ////////////////////////////////////////////////////////////////////////
    task automatic t_regs;
        apb(1'b0, `AMM_CTRL_OFS, 32'h0);
        cmp("ctrl", 32'h0, rd);
        apb(1'b0, `AMM_LOWER_OFS, 32'h0);
        cmp("lower", 32'h0, rd);
        apb(1'b0, `AMM_UPPER_OFS, 32'h0);
        cmp("upper", 32'h3E8, rd);
        cmp("okay", 32'h0, {31'h0, err});
        apb(1'b1, 12'h020, 32'h5);
        cmp("slverr", 32'h1, {31'h0, err});
        apb(1'b0, 12'h020, 32'h0);
        cmp("unmapped", 32'h0, rd);
        apb(1'b1, `AMM_UPPER_OFS, 32'h7FF);
        apb(1'b0, `AMM_UPPER_OFS, 32'h0);
        cmp("upper_sat", 32'h3E8, rd);
    endtask : t_regs

    task automatic t_modes;
        drive(10'h12C, 1'b1, 1'b0);
        drive(10'h2BC, 1'b1, 1'b0);
        chk_res(10'h12C);
        apb(1'b0, `AMM_EXTREME_OFS, 32'h0);
        cmp("extreme", 32'h02BC012C, rd);
        apb(1'b1, `AMM_CTRL_OFS, 32'h1);
        drive(10'h2BC, 1'b1, 1'b0);
        chk_res(10'h2BC);
        apb(1'b1, `AMM_CTRL_OFS, 32'h2);
        drive(10'h2BC, 1'b1, 1'b0);
        chk_res(10'h12C);
        drive(10'h2BC, 1'b1, 1'b1);
        chk_res(10'h2BC);
        drive(10'h2BC, 1'b1, 1'b0);
        chk_res(10'h12C);
        apb(1'b1, `AMM_CTRL_OFS, 32'h3);
        drive(10'h190, 1'b1, 1'b0);
        chk_res(10'h190);
        apb(1'b1, `AMM_CTRL_OFS, 32'h8);
        drive(10'h1A4, 1'b1, 1'b0);
        chk_res(10'h1A4);
    endtask : t_modes

    task automatic t_clamp;
        apb(1'b1, `AMM_LOWER_OFS, 32'h15E);
        apb(1'b1, `AMM_UPPER_OFS, 32'h258);
        apb(1'b1, `AMM_CTRL_OFS, 32'h0);
        drive(10'h1A4, 1'b1, 1'b0);
        chk_res(10'h15E);
        apb(1'b1, `AMM_CTRL_OFS, 32'h1);
        drive(10'h1A4, 1'b1, 1'b0);
        chk_res(10'h258);
        apb(1'b1, `AMM_LOWER_OFS, 32'h0);
        apb(1'b1, `AMM_UPPER_OFS, 32'h3E8);
    endtask : t_clamp

    task automatic t_disable;
        apb(1'b1, `AMM_CTRL_OFS, 32'h3);
        drive(10'h190, 1'b1, 1'b0);
        drive(10'h384, 1'b0, 1'b0);
        chk_res(10'h190);
        apb(1'b1, `AMM_CTRL_OFS, 32'h7);
        drive(10'h384, 1'b0, 1'b0);
        chk_res(10'h000);
        apb(1'b0, `AMM_EXTREME_OFS, 32'h0);
        cmp("extreme_clr", 32'h0, rd);
        drive(10'h0C8, 1'b1, 1'b0);
        chk_res(10'h0C8);
        apb(1'b1, `AMM_CTRL_OFS, 32'h4);
        drive(10'h0C8, 1'b1, 1'b0);
        chk_res(10'h0C8);
    endtask : t_disable

    ////////////////////////////////////////////////////////////////////////
    initial begin
        repeat (4) @(posedge clk);
        arst_n <= 1'b1;
        repeat (3) @(posedge clk);
        t_regs();
        t_modes();
        t_clamp();
        t_disable();
        test_done();
    end

    initial begin
        repeat (20000) @(posedge clk);
        failures++;
        test_done();
    end
endmodule : testbench
